// ---- atpg_pkg.sv ----
// constants shared by the test pattern generator block
//----------------------------------------------------------------------
//----------------------------------------------------------------------

package atpg_pkg;

  // datapath widths
  localparam int SMP_W = 14;
  localparam int IDX_W = 12;
  localparam int ADR_W = 14;

  // register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SEL_A   = 12'h550;
  localparam logic [IDX_W-1:0] IDX_UP_FRST = 12'h551;
  localparam logic [IDX_W-1:0] IDX_UP_LAST = 12'h558;
  localparam logic [IDX_W-1:0] IDX_DDC0    = 12'h327;
  localparam logic [IDX_W-1:0] IDX_DDC1    = 12'h347;
  localparam logic [IDX_W-1:0] IDX_SEL_B   = 12'h5f0;
  localparam logic [IDX_W-1:0] IDX_CHIP    = 12'h5f1;
  localparam logic [IDX_W-1:0] IDX_STAT    = 12'h5f2;

  // register reset value
  localparam logic [7:0] REG_RST = 8'h00;

  // pattern select fields
  localparam int SEL_MODE_LSB  = 0;
  localparam int BIT_PNL_RST   = 4;
  localparam int BIT_PNS_RST   = 5;
  localparam int BIT_USER_SNGL = 7;

  // downconverter control and chip mode fields
  localparam int BIT_DDC_EN_I = 0;
  localparam int BIT_DDC_EN_Q = 2;
  localparam int BIT_CHIP_DDC = 0;

  // test mode codes
  localparam logic [3:0] TM_OFF   = 4'h0;
  localparam logic [3:0] TM_MID   = 4'h1;
  localparam logic [3:0] TM_PFS   = 4'h2;
  localparam logic [3:0] TM_NFS   = 4'h3;
  localparam logic [3:0] TM_CHK   = 4'h4;
  localparam logic [3:0] TM_PNL   = 4'h5;
  localparam logic [3:0] TM_PNS   = 4'h6;
  localparam logic [3:0] TM_TGL   = 4'h7;
  localparam logic [3:0] TM_USER  = 4'h8;
  localparam logic [3:0] TM_RAMP  = 4'hf;

  // fixed words
  localparam logic [SMP_W-1:0] W_MID   = 14'h0000;
  localparam logic [SMP_W-1:0] W_PFS   = 14'h1fff;
  localparam logic [SMP_W-1:0] W_NFS   = 14'h2000;
  localparam logic [SMP_W-1:0] W_CHK0  = 14'h1555;
  localparam logic [SMP_W-1:0] W_CHK1  = 14'h2aaa;
  localparam logic [SMP_W-1:0] W_ZERO  = 14'h0000;
  localparam logic [SMP_W-1:0] W_ONES  = 14'h3fff;

  // pseudo-noise seeds and feedback taps
  localparam int PNL_W = 23;
  localparam int PNS_W = 9;
  localparam logic [PNL_W-1:0] PNL_SEED = 23'h003aff;
  localparam logic [PNS_W-1:0] PNS_SEED = 9'h092;
  localparam int PNL_TAP = 5;
  localparam int PNS_TAP = 4;

  // user patterns
  localparam int UP_NUM = 4;
  localparam int UP_MSB = 15;
  localparam int UP_LSB = 2;
  localparam logic [1:0] UP_LAST = 2'h3;

endpackage : atpg_pkg

// ---- atpg_chan.sv ----
// one channel of pattern generation
`timescale 1ns/1ps

module atpg_chan
  import atpg_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic [3:0]       mode,
  input  wire logic             user_single,
  input  wire logic             pnl_hold,
  input  wire logic             pns_hold,
  input  wire logic [63:0]      user_pat,
  // pattern out
  output logic      [SMP_W-1:0] pat_q,
  output logic                  active_q
);

  logic [3:0]       mode_q;
  logic             phase_q, phase_d;
  logic [SMP_W-1:0] ramp_q, ramp_d, pat_d;
  logic [1:0]       uidx_q, uidx_d;
  logic             udone_q, udone_d, active_d;
  logic [PNL_W-1:0] pnl_q, pnl_d;
  logic [PNS_W-1:0] pns_q, pns_d;

  // long sequence: 14 bits per sample, oldest bit first
  function automatic void pnl_run(input logic [PNL_W-1:0] s,
                                  output logic [PNL_W-1:0] n,
                                  output logic [SMP_W-1:0] w);
    n = s;
    w = '0;
    for (int i = 0; i < SMP_W; i++) begin
      w[SMP_W-1-i] = n[0];
      n = {n[0] ^ n[PNL_TAP], n[PNL_W-1:1]};
    end
  endfunction

  // short sequence: 14 bits per sample, oldest bit first
  function automatic void pns_run(input logic [PNS_W-1:0] s,
                                  output logic [PNS_W-1:0] n,
                                  output logic [SMP_W-1:0] w);
    n = s;
    w = '0;
    for (int i = 0; i < SMP_W; i++) begin
      w[SMP_W-1-i] = n[0];
      n = {n[0] ^ n[PNS_TAP], n[PNS_W-1:1]};
    end
  endfunction

  // next pattern word and generator state; counters advance every clock, each pn register only in its own mode
  always_comb begin
    logic             restart, ph;
    logic [SMP_W-1:0] rmp, wl, ws;
    logic [1:0]       ui;
    logic             ud;
    logic [PNL_W-1:0] lcur;
    logic [PNS_W-1:0] scur;
    restart = (mode != mode_q);
    ph      = restart ? 1'b0 : phase_q;
    rmp     = restart ? W_ZERO : ramp_q;
    ui      = restart ? 2'h0 : uidx_q;
    ud      = restart ? 1'b0 : udone_q;
    lcur    = (pnl_hold || restart) ? PNL_SEED : pnl_q;
    scur    = (pns_hold || restart) ? PNS_SEED : pns_q;
    pnl_run(lcur, pnl_d, wl);
    pns_run(scur, pns_d, ws);
    if (pnl_hold || mode != TM_PNL) pnl_d = lcur;
    if (pns_hold || mode != TM_PNS) pns_d = scur;
    phase_d  = ~ph;
    ramp_d   = rmp + 14'h0001;
    uidx_d   = ui + 2'h1;
    udone_d  = ud || (user_single && ui == UP_LAST);
    active_d = 1'b1;
    case (mode)
      TM_MID:  pat_d = W_MID;
      TM_PFS:  pat_d = W_PFS;
      TM_NFS:  pat_d = W_NFS;
      TM_CHK:  pat_d = ph ? W_CHK1 : W_CHK0;
      TM_PNL:  pat_d = wl;
      TM_PNS:  pat_d = ws;
      TM_TGL:  pat_d = ph ? W_ONES : W_ZERO;
      TM_USER: pat_d = ud ? W_ZERO
                 : user_pat[{ui, 4'h0} + UP_LSB +: SMP_W];
      TM_RAMP: pat_d = rmp;
      default: begin
        pat_d    = W_ZERO;
        active_d = 1'b0;
      end
    endcase
  end

  // generator registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q   <= TM_OFF;
      phase_q  <= 1'b0;
      ramp_q   <= W_ZERO;
      uidx_q   <= 2'h0;
      udone_q  <= 1'b0;
      pnl_q    <= PNL_SEED;
      pns_q    <= PNS_SEED;
      pat_q    <= W_ZERO;
      active_q <= 1'b0;
    end else begin
      mode_q   <= mode;
      phase_q  <= phase_d;
      ramp_q   <= ramp_d;
      uidx_q   <= uidx_d;
      udone_q  <= udone_d;
      pnl_q    <= pnl_d;
      pns_q    <= pns_d;
      pat_q    <= pat_d;
      active_q <= active_d;
    end
  end

endmodule // atpg_chan

// ---- atpg_top.sv ----
// test pattern generator top with wishbone register slave
`timescale 1ns/1ps

module atpg_top
  import atpg_pkg::*;
(
  // clock and reset
  input  wire logic             CORE_CLK,
  input  wire logic             RESETN,
  // wishbone slave
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  input  wire logic             WB_WE_I,
  input  wire logic [ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]       WB_SEL_I,
  input  wire logic [31:0]      WB_DAT_I,
  output logic      [31:0]      WB_DAT_O,
  output logic                  WB_ACK_O,
  // converter samples
  input  wire logic [SMP_W-1:0] ADC_A_DATA,
  input  wire logic [SMP_W-1:0] ADC_B_DATA,
  // downconverter samples
  input  wire logic [SMP_W-1:0] DDC0_I_DATA,
  input  wire logic [SMP_W-1:0] DDC0_Q_DATA,
  input  wire logic [SMP_W-1:0] DDC1_I_DATA,
  input  wire logic [SMP_W-1:0] DDC1_Q_DATA,
  // samples to the output formatter
  output logic      [SMP_W-1:0] FMT_A_DATA,
  output logic      [SMP_W-1:0] FMT_B_DATA,
  output logic      [SMP_W-1:0] FMT_DDC0_I,
  output logic      [SMP_W-1:0] FMT_DDC0_Q,
  output logic      [SMP_W-1:0] FMT_DDC1_I,
  output logic      [SMP_W-1:0] FMT_DDC1_Q,
  // test status
  output logic                  TEST_ACTIVE
);

  //--------------------------------------------------------------------
  // register file
  //--------------------------------------------------------------------

  logic [7:0]       sel_a_q, sel_a_d;
  logic [7:0]       sel_b_q, sel_b_d;
  logic [7:0]       ddc0_q, ddc0_d;
  logic [7:0]       ddc1_q, ddc1_d;
  logic [7:0]       chip_q, chip_d;
  logic [7:0]       upat_q [0:7];
  logic [7:0]       upat_d [0:7];
  logic             ack_q, ack_d;
  logic [31:0]      rdat_q, rdat_d;
  logic [IDX_W-1:0] idx;
  logic [2:0]       up_sel;
  logic             up_hit;
  logic             wr_en;
  logic [63:0]      user_pat;
  logic [SMP_W-1:0] pat_a, pat_b;
  logic             act_a, act_b;

  // address decode
  assign idx    = WB_ADR_I[ADR_W-1:2];
  assign up_hit = (idx >= IDX_UP_FRST) && (idx <= IDX_UP_LAST);
  assign up_sel = up_hit ? 3'(idx - IDX_UP_FRST) : 3'h0;
  assign wr_en  = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0]
                  && !ack_q;

  // write decode, read mux and acknowledge
  always_comb begin
    sel_a_d = sel_a_q;
    sel_b_d = sel_b_q;
    ddc0_d  = ddc0_q;
    ddc1_d  = ddc1_q;
    chip_d  = chip_q;
    for (int i = 0; i < 8; i++) begin
      upat_d[i] = upat_q[i];
    end
    ack_d  = WB_CYC_I && WB_STB_I && !ack_q;
    rdat_d = 32'h0000_0000;
    if (wr_en) begin
      case (idx)
        IDX_SEL_A: sel_a_d = WB_DAT_I[7:0];
        IDX_SEL_B: sel_b_d = WB_DAT_I[7:0];
        IDX_DDC0:  ddc0_d  = WB_DAT_I[7:0];
        IDX_DDC1:  ddc1_d  = WB_DAT_I[7:0];
        IDX_CHIP:  chip_d  = WB_DAT_I[7:0];
        default: begin
          if (up_hit) upat_d[up_sel] = WB_DAT_I[7:0];
        end
      endcase
    end
    if (WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_q) begin
      case (idx)
        IDX_SEL_A: rdat_d[7:0] = sel_a_q;
        IDX_SEL_B: rdat_d[7:0] = sel_b_q;
        IDX_DDC0:  rdat_d[7:0] = ddc0_q;
        IDX_DDC1:  rdat_d[7:0] = ddc1_q;
        IDX_CHIP:  rdat_d[7:0] = chip_q;
        IDX_STAT:  rdat_d[1:0] = {act_b, act_a};
        default: begin
          if (up_hit) rdat_d[7:0] = upat_q[up_sel];
        end
      endcase
    end
  end

  // register file flip-flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sel_a_q <= REG_RST;
      sel_b_q <= REG_RST;
      ddc0_q  <= REG_RST;
      ddc1_q  <= REG_RST;
      chip_q  <= REG_RST;
      for (int i = 0; i < 8; i++) begin
        upat_q[i] <= REG_RST;
      end
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
    end else begin
      sel_a_q <= sel_a_d;
      sel_b_q <= sel_b_d;
      ddc0_q  <= ddc0_d;
      ddc1_q  <= ddc1_d;
      chip_q  <= chip_d;
      for (int i = 0; i < 8; i++) begin
        upat_q[i] <= upat_d[i];
      end
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  //--------------------------------------------------------------------
  // pattern generators, one per channel
  //--------------------------------------------------------------------

  // user pattern n is the byte pair low then high
  assign user_pat = {upat_q[7], upat_q[6], upat_q[5], upat_q[4],
                     upat_q[3], upat_q[2], upat_q[1], upat_q[0]};

  // channel a generator, runs on CORE_CLK alone
  atpg_chan u_chan_a (
    .clk         (CORE_CLK),
    .rst_n       (RESETN),
    .mode        (sel_a_q[SEL_MODE_LSB +: 4]),
    .user_single (sel_a_q[BIT_USER_SNGL]),
    .pnl_hold    (sel_a_q[BIT_PNL_RST]),
    .pns_hold    (sel_a_q[BIT_PNS_RST]),
    .user_pat    (user_pat),
    .pat_q       (pat_a),
    .active_q    (act_a)
  );

  // channel b generator
  atpg_chan u_chan_b (
    .clk         (CORE_CLK),
    .rst_n       (RESETN),
    .mode        (sel_b_q[SEL_MODE_LSB +: 4]),
    .user_single (sel_b_q[BIT_USER_SNGL]),
    .pnl_hold    (sel_b_q[BIT_PNL_RST]),
    .pns_hold    (sel_b_q[BIT_PNS_RST]),
    .user_pat    (user_pat),
    .pat_q       (pat_b),
    .active_q    (act_b)
  );

  //--------------------------------------------------------------------
  // output selection toward the formatter
  //--------------------------------------------------------------------

  logic             ddc_mode;
  logic             d0i_tst, d0q_tst, d1i_tst, d1q_tst;
  logic [SMP_W-1:0] fa_q, fa_d, fb_q, fb_d;
  logic [SMP_W-1:0] d0i_q, d0i_d, d0q_q, d0q_d;
  logic [SMP_W-1:0] d1i_q, d1i_d, d1q_q, d1q_d;
  logic             tact_q, tact_d;

  // per downconverter enables only count in downconverter mode
  assign ddc_mode = chip_q[BIT_CHIP_DDC];
  assign d0i_tst  = ddc_mode && ddc0_q[BIT_DDC_EN_I] && act_a;
  assign d0q_tst  = ddc_mode && ddc0_q[BIT_DDC_EN_Q] && act_b;
  assign d1i_tst  = ddc_mode && ddc1_q[BIT_DDC_EN_I] && act_a;
  assign d1q_tst  = ddc_mode && ddc1_q[BIT_DDC_EN_Q] && act_b;

  // converter data is dropped whenever a pattern replaces it
  always_comb begin
    fa_d   = act_a   ? pat_a : ADC_A_DATA;
    fb_d   = act_b   ? pat_b : ADC_B_DATA;
    d0i_d  = d0i_tst ? pat_a : DDC0_I_DATA;
    d0q_d  = d0q_tst ? pat_b : DDC0_Q_DATA;
    d1i_d  = d1i_tst ? pat_a : DDC1_I_DATA;
    d1q_d  = d1q_tst ? pat_b : DDC1_Q_DATA;
    tact_d = act_a || act_b;
  end

  // output flip-flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fa_q   <= W_ZERO;
      fb_q   <= W_ZERO;
      d0i_q  <= W_ZERO;
      d0q_q  <= W_ZERO;
      d1i_q  <= W_ZERO;
      d1q_q  <= W_ZERO;
      tact_q <= 1'b0;
    end else begin
      fa_q   <= fa_d;
      fb_q   <= fb_d;
      d0i_q  <= d0i_d;
      d0q_q  <= d0q_d;
      d1i_q  <= d1i_d;
      d1q_q  <= d1q_d;
      tact_q <= tact_d;
    end
  end

  assign FMT_A_DATA  = fa_q;
  assign FMT_B_DATA  = fb_q;
  assign FMT_DDC0_I  = d0i_q;
  assign FMT_DDC0_Q  = d0q_q;
  assign FMT_DDC1_I  = d1i_q;
  assign FMT_DDC1_Q  = d1q_q;
  assign TEST_ACTIVE = tact_q;

endmodule // atpg_top

// ---- atpg_props.sv ----
// concurrent checks on the test pattern generator ports
`timescale 1ns/1ps

module atpg_props
  import atpg_pkg::*;
(
  // clock and reset
  input wire logic             CORE_CLK,
  input wire logic             RESETN,
  // register bus
  input wire logic             WB_CYC_I,
  input wire logic             WB_STB_I,
  input wire logic             WB_WE_I,
  input wire logic [31:0]      WB_DAT_O,
  input wire logic             WB_ACK_O,
  // samples
  input wire logic [SMP_W-1:0] ADC_A_DATA,
  input wire logic [SMP_W-1:0] ADC_B_DATA,
  input wire logic [SMP_W-1:0] DDC0_I_DATA,
  input wire logic [SMP_W-1:0] FMT_A_DATA,
  input wire logic [SMP_W-1:0] FMT_B_DATA,
  input wire logic [SMP_W-1:0] FMT_DDC0_I,
  input wire logic             TEST_ACTIVE
);
  //--------------------------------------------------------------------
  // settle counters
  //--------------------------------------------------------------------
  logic [1:0] run_q;
  logic [1:0] run_d;
  logic [1:0] quiet_q;
  logic [1:0] quiet_d;
  logic       calm;

  // cycles since reset and since the last bus request, saturating at 3;
  // a mode write lands at the request's first edge, together with its answer
  always_comb begin
    run_d   = (run_q == 2'h3) ? run_q : run_q + 2'h1;
    quiet_d = (quiet_q == 2'h3) ? quiet_q : quiet_q + 2'h1;
    if (WB_CYC_I && WB_STB_I) begin
      quiet_d = 2'h0;
    end
  end

  // register the counters
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      run_q   <= 2'h0;
      quiet_q <= 2'h0;
    end else begin
      run_q   <= run_d;
      quiet_q <= quiet_d;
    end
  end

  // patterns only judged once no mode write can still be in flight
  assign calm = (run_q == 2'h3) && (quiet_q == 2'h3);

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  //--------------------------------------------------------------------
  // properties
  //--------------------------------------------------------------------
  property p_ack_next;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("bus answer missing one cycle after request");
  property p_ack_pulse;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus answer longer than one cycle");
  property p_ack_cause;
    $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("bus answer without request");
  property p_rd_upper;
    WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits not zero");
  property p_pass;
    calm && !TEST_ACTIVE |-> FMT_A_DATA == $past(ADC_A_DATA)
      && FMT_B_DATA == $past(ADC_B_DATA);
  endproperty
  a_pass: assert property (p_pass)
    else $error("converter data not passed with tests off");
  property p_ddc_src;
    calm |-> FMT_DDC0_I == FMT_A_DATA || FMT_DDC0_I == $past(DDC0_I_DATA);
  endproperty
  a_ddc_src: assert property (p_ddc_src)
    else $error("in-phase output neither channel a pattern nor input");
  property p_chk;
    calm && TEST_ACTIVE && $past(FMT_A_DATA) == W_CHK0
      && FMT_A_DATA == W_CHK1 |=> FMT_A_DATA == W_CHK0;
  endproperty
  a_chk: assert property (p_chk)
    else $error("checkerboard did not alternate");
  property p_tgl;
    calm && TEST_ACTIVE && $past(FMT_A_DATA) == W_ONES
      && FMT_A_DATA == W_ZERO |=> FMT_A_DATA == W_ONES;
  endproperty
  a_tgl: assert property (p_tgl)
    else $error("word toggle did not alternate");
  property p_ramp;
    calm && TEST_ACTIVE && FMT_A_DATA == $past(FMT_A_DATA) + 14'h1
      && $past(FMT_A_DATA) == $past(FMT_A_DATA, 2) + 14'h1
      |=> FMT_A_DATA == $past(FMT_A_DATA) + 14'h1;
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp did not step by one");

endmodule // atpg_props

// ---- atpg_fmt_sink.sv ----
// downstream formatter stand-in taking one sample per clock
`timescale 1ns/1ps

module atpg_fmt_sink
  import atpg_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // samples from the generator
  input  wire logic [SMP_W-1:0] a_data,
  input  wire logic             active,
  // what was taken
  output logic      [15:0]      n_words,
  output logic      [SMP_W-1:0] last_a
);
  // takes a word every clock with no handshake back, counts test words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_words <= 16'h0000;
      last_a  <= 14'h0000;
    end else begin
      last_a <= a_data;
      if (active) begin
        n_words <= n_words + 16'h0001;
      end
    end
  end
endmodule // atpg_fmt_sink

// ---- test_adc_test_pattern_generator.sv ----
// self-checking bench for the test pattern generator
`timescale 1ns/1ps

module test_adc_test_pattern_generator;
  import atpg_pkg::*;
  //--------------------------------------------------------------------
  // signals
  //--------------------------------------------------------------------
  logic             core_clk;
  logic             rst_n;
  logic             wb_cyc;
  logic             wb_stb;
  logic             wb_we;
  logic [ADR_W-1:0] wb_adr;
  logic [3:0]       wb_sel;
  logic [31:0]      wb_wdat;
  logic [31:0]      wb_rdat;
  logic             wb_ack;
  logic             test_act;
  logic [SMP_W-1:0] din [6];
  logic [SMP_W-1:0] prev [6];
  logic [SMP_W-1:0] fmt [6];
  logic [13:0]      cnt;
  logic [15:0]      sink_words;
  int               n_errors;
  int               compares;
  int               cycles;

  atpg_top i_dut (.CORE_CLK(core_clk), .RESETN(rst_n), .WB_CYC_I(wb_cyc),
    .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel),
    .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack),
    .ADC_A_DATA(din[0]), .ADC_B_DATA(din[1]), .DDC0_I_DATA(din[2]),
    .DDC0_Q_DATA(din[3]), .DDC1_I_DATA(din[4]), .DDC1_Q_DATA(din[5]),
    .FMT_A_DATA(fmt[0]), .FMT_B_DATA(fmt[1]), .FMT_DDC0_I(fmt[2]),
    .FMT_DDC0_Q(fmt[3]), .FMT_DDC1_I(fmt[4]), .FMT_DDC1_Q(fmt[5]),
    .TEST_ACTIVE(test_act));
  atpg_fmt_sink i_sink (.clk(core_clk), .rst_n(rst_n), .a_data(fmt[0]),
    .active(test_act), .n_words(sink_words), .last_a());

  // 50 ns clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // live converter input that a test must ignore, and its one-cycle echo
  always @(posedge core_clk) begin
    cnt <= cnt + 14'h1;
    for (int k = 0; k < 6; k++) begin
      din[k] <= (k == 0) ? {cnt[12:0], 1'b0} : cnt ^ 14'(k * 1234);
    end
    prev <= din;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end

  //--------------------------------------------------------------------
  // shared tasks
  //--------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle, held until ack is seen, then released
  task automatic wb(input logic [11:0] idx, input logic we, input logic [3:0]
                    sel, input logic [7:0] wd, output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= sel;
    wb_adr <= {idx, 2'b00};
    wb_wdat <= {24'h0, wd};
    // ack and read data are taken as sampled at the rising edge itself
    do begin
      @(posedge core_clk);
      t++;
    end while (wb_ack !== 1'b1 && t < 20);
    chk("ack", {31'h0, wb_ack}, 32'h1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
    logic [31:0] v;
    wb(idx, 1'b1, 4'h1, wd, v);
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    wb(idx, 1'b0, 4'h0, 8'h00, v);
    chk("register", v, exp);
  endtask

  // select a mode, then judge the words from the first one on
  task automatic run_seq(input logic [11:0] idx, input logic [7:0] val,
                         input int port, input logic [13:0] exp [5],
                         input int n);
    wr(idx, val);
    @(posedge core_clk);
    for (int k = 0; k < n; k++) begin
      #1;
      chk("pattern", {18'h0, fmt[port]}, {18'h0, exp[k]});
      @(posedge core_clk);
    end
  endtask

  task automatic t_pass(input logic [7:0] val);
    wr(IDX_SEL_A, val);
    repeat (3) @(posedge core_clk);
    #1;
    foreach (fmt[k]) chk("pass", {18'h0, fmt[k]}, {18'h0, prev[k]});
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  //--------------------------------------------------------------------
  // main sequence
  //--------------------------------------------------------------------
  initial begin
    logic [15:0] up [4];
    logic [31:0] junk;
    up = '{16'ha5c4, 16'h3c78, 16'h9e10, 16'h47fc};
    {rst_n, wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_wdat} = '0;
    {cnt, n_errors, compares, cycles} = '0;
    din = '{default: '0};
    prev = '{default: '0};
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (up[k]) rdc(IDX_SEL_A + 12'(k), 32'h0);
    rdc(IDX_DDC0, 32'h0);
    rdc(IDX_DDC1, 32'h0);
    wb(IDX_UP_LAST, 1'b1, 4'h0, 8'h5a, junk);
    rdc(IDX_UP_LAST, 32'h0);
    wr(12'h100, 8'h5a);
    rdc(12'h100, 32'h0);
    wr(IDX_STAT, 8'hff);
    rdc(IDX_STAT, 32'h0);
    t_pass(8'h00);
    t_pass(8'h09);
    run_seq(IDX_SEL_A, 8'h01, 0, '{default: W_MID}, 3);
    run_seq(IDX_SEL_A, 8'h02, 0, '{default: W_PFS}, 3);
    run_seq(IDX_SEL_A, 8'h03, 0, '{default: W_NFS}, 3);
    #1;
    chk("active", {31'h0, test_act}, 32'h1);
    run_seq(IDX_SEL_A, 8'h04, 0, '{14'h1555, 14'h2aaa, 14'h1555, 14'h2aaa,
            14'h1555}, 5);
    run_seq(IDX_SEL_A, 8'h05, 0, '{14'h3fd7, 14'h0002, 14'h26e0, 14'h0a3d,
            14'h1ca6}, 5);
    run_seq(IDX_SEL_B, 8'h06, 1, '{14'h125b, 14'h3c9a, 14'h2660, 14'h0c65,
            14'h0697}, 5);
    run_seq(IDX_SEL_A, 8'h07, 0, '{14'h0, 14'h3fff, 14'h0, 14'h3fff, 14'h0},
            5);
    run_seq(IDX_SEL_A, 8'h0f, 0, '{14'h0, 14'h1, 14'h2, 14'h3, 14'h4}, 5);
    wr(IDX_SEL_A, 8'h05);
    repeat (6) @(posedge core_clk);
    wr(IDX_SEL_A, 8'h15);
    repeat (4) @(posedge core_clk);
    run_seq(IDX_SEL_A, 8'h05, 0, '{14'h3fd7, 14'h0002, 14'h26e0, 14'h0a3d,
            14'h1ca6}, 3);
    wr(IDX_SEL_B, 8'h26);
    repeat (4) @(posedge core_clk);
    run_seq(IDX_SEL_B, 8'h06, 1, '{14'h125b, 14'h3c9a, 14'h2660, 14'h0c65,
            14'h0697}, 3);
    foreach (up[k]) begin
      wr(IDX_UP_FRST + 12'(2 * k), up[k][7:0]);
      wr(IDX_UP_FRST + 12'(2 * k + 1), up[k][15:8]);
    end
    run_seq(IDX_SEL_A, 8'h08, 0, '{14'h2971, 14'h0f1e, 14'h2784, 14'h11ff,
            14'h2971}, 5);
    wr(IDX_SEL_A, 8'h00);
    run_seq(IDX_SEL_A, 8'h88, 0, '{14'h2971, 14'h0f1e, 14'h2784, 14'h11ff,
            14'h0}, 5);
    wr(IDX_CHIP, 8'h01);
    wr(IDX_DDC0, 8'h05);
    wr(IDX_DDC1, 8'h04);
    wr(IDX_SEL_A, 8'h04);
    run_seq(IDX_SEL_B, 8'h07, 3, '{14'h0, 14'h3fff, 14'h0, 14'h3fff, 14'h0},
            5);
    run_seq(IDX_SEL_A, 8'h0f, 2, '{14'h0, 14'h1, 14'h2, 14'h3, 14'h4}, 5);
    run_seq(IDX_SEL_B, 8'h0f, 5, '{14'h0, 14'h1, 14'h2, 14'h3, 14'h4},
            5);
    #1;
    chk("ddc1 pass", {18'h0, fmt[4]}, {18'h0, prev[4]});
    rdc(IDX_STAT, 32'h3);
    wr(IDX_DDC0, 8'h01);
    repeat (3) @(posedge core_clk);
    #1;
    chk("ddc0 q pass", {18'h0, fmt[3]}, {18'h0, prev[3]});
    wr(IDX_SEL_A, 8'h00);
    wr(IDX_SEL_B, 8'h00);
    repeat (3) @(posedge core_clk);
    #1;
    chk("idle", {31'h0, test_act}, 32'h0);
    chk("sink", {31'h0, sink_words != 16'h0}, 32'h1);
    report_and_stop();
  end
endmodule // test_adc_test_pattern_generator

bind atpg_top atpg_props i_props (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ADC_A_DATA(ADC_A_DATA),
  .ADC_B_DATA(ADC_B_DATA), .DDC0_I_DATA(DDC0_I_DATA),
  .FMT_A_DATA(FMT_A_DATA), .FMT_B_DATA(FMT_B_DATA),
  .FMT_DDC0_I(FMT_DDC0_I), .TEST_ACTIVE(TEST_ACTIVE));
